/* File: design/acc_pkg.sv */
// Operation
// - pin codes route gated pins; next codes low ref
// - reserved codes give an undefined result
// - temp sensor, high ref, low ref codes
// - all-ones code switches converter off, isolated
// - four selectable conversion clock sources
// - alternate clock divided by programmed divider
// - alternate clock keeps running in wait
// - counter match starts conversion when enabled
// - match triggers regardless of counter interrupt
// - trigger works in run, wait, stop3
// - two pin enable registers, sixteen enables
// - twelve-bit successive approximation, selectable format
// - single and continuous modes, idle after single
// - optional compare less-than or greater-equal
// - done flag with interrupt request
// - sample time and speed/power configurable
// - control write aborts, restarts unless off or hardware trigger enabled
// - done clears on control write, result read
package acc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL1  = 8'h00;
	localparam logic [7:0] OFS_CTRL2  = 8'h04;
	localparam logic [7:0] OFS_RESULT = 8'h08;
	localparam logic [7:0] OFS_CMPV   = 8'h0c;
	localparam logic [7:0] OFS_CFG    = 8'h10;
	localparam logic [7:0] OFS_PIN1   = 8'h14;
	localparam logic [7:0] OFS_PIN2   = 8'h18;
	// control 1 fields
	localparam int C1_DONE = 7;
	localparam int C1_IEN  = 6;
	localparam int C1_CONT = 5;
	// control 2 fields
	localparam int C2_ACT  = 7;
	localparam int C2_HWT  = 6;
	localparam int C2_CMPE = 5;
	localparam int C2_CMPG = 4;
	// config fields
	localparam int CF_LP   = 7;
	localparam int CF_DIV  = 5;
	localparam int CF_LSMP = 4;
	localparam int CF_MODE = 2;
	localparam int CF_CSEL = 0;
	// input select codes
	localparam logic [4:0] CODE_PIN_LAST   = 5'h0b;
	localparam logic [4:0] CODE_VREFL_LAST = 5'h14;
	localparam logic [4:0] CODE_TEMP       = 5'h1a;
	localparam logic [4:0] CODE_BGAP       = 5'h1b;
	localparam logic [4:0] CODE_VREFH      = 5'h1d;
	localparam logic [4:0] CODE_VREFL      = 5'h1e;
	localparam logic [4:0] CODE_OFF        = 5'h1f;
	// reset values
	localparam logic [4:0] CODE_RST = 5'h1f;
	// clock sources
	localparam logic [1:0] CS_BUS  = 2'h0;
	localparam logic [1:0] CS_HALF = 2'h1;
	localparam logic [1:0] CS_ASYN = 2'h2;
	localparam logic [1:0] CS_ALT  = 2'h3;
	// result formats
	localparam logic [1:0] FM_8  = 2'h0;
	localparam logic [1:0] FM_12 = 2'h1;
	localparam logic [1:0] FM_10 = 2'h2;
	// timing in conversion clocks
	localparam logic [4:0] SMP_SHORT = 5'h03;
	localparam logic [4:0] SMP_LONG  = 5'h13;
	localparam logic [3:0] MSB_IDX   = 4'hb;
	localparam int RES_W = 12;
	localparam int RTC_W = 8;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SMP  = 2'b01,
		ST_CONV = 2'b11,
		ST_FIN  = 2'b10
	} acc_state_t;
endpackage : acc_pkg

/* File: design/acc_clk_div.sv */
`timescale 1ns/10ps
module acc_clk_div
	import acc_pkg::*;
(
	input  wire logic       ref_clk,   // clock
	input  wire logic       srst,      // reset
	input  wire logic       clr,       // restart division
	input  wire logic       src_tick,  // selected source enable
	input  wire logic [1:0] div_sel,   // divide by 1,2,4,8
	output logic            tick_q     // conversion clock enable
);
	logic [2:0] cnt_q, cnt_d;
	logic       tick_d;
	logic [2:0] lim;

	// divide the source ticks by the programmed setting
	always_comb begin
		lim = 3'h0;
		unique case (div_sel)
			2'h0: lim = 3'h0;
			2'h1: lim = 3'h1;
			2'h2: lim = 3'h3;
			2'h3: lim = 3'h7;
		endcase
		cnt_d  = cnt_q;
		tick_d = 1'b0;
		if (clr) begin
			cnt_d = 3'h0;
		end else if (src_tick) begin
			if (cnt_q >= lim) begin
				cnt_d  = 3'h0;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 3'h1;
			end
		end
	end

	// register the divider
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cnt_q  <= 3'h0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end
endmodule : acc_clk_div

/* File: design/acc_ctrl.sv */
`timescale 1ns/10ps
module acc_ctrl
	import acc_pkg::*;
(
	input  wire logic             ref_clk,          // 10 MHz clock
	input  wire logic             srst,             // sync reset, high
	input  wire logic             hsel,             // slave select
	input  wire logic [31:0]      haddr,            // address
	input  wire logic [1:0]       htrans,           // transfer type
	input  wire logic             hwrite,           // write
	input  wire logic [2:0]       hsize,            // size, word only
	input  wire logic [31:0]      hwdata,           // write data
	input  wire logic             hready,           // bus ready
	output logic [31:0]           hrdata,           // read data
	output logic                  hreadyout,        // slave ready
	output logic                  hresp,            // always okay
	input  wire logic             wait_mode,        // processor waits
	input  wire logic             stop3_mode,       // stop3 active
	input  wire logic             local_async_conv_clock, // local clock tick
	input  wire logic             alternate_conv_clock,   // ext ref tick
	input  wire logic [RTC_W-1:0] rtc_count_value,  // counter value
	input  wire logic [RTC_W-1:0] rtc_modulo_value, // counter modulo
	input  wire logic             cmp_hi,           // input above dac
	output logic [11:0]           pin_route,        // pin switches
	output logic                  sel_vrefl,        // low ref selected
	output logic                  sel_vrefh,        // high ref selected
	output logic                  sel_temp,         // temp sensor
	output logic                  sel_bandgap,      // bandgap
	output logic                  conv_off,         // converter off
	output logic                  sample_en,        // sample switch
	output logic [RES_W-1:0]      dac_code,         // trial code
	output logic                  low_power,        // low power bias
	output logic                  conv_irq          // done interrupt
);
	////////////////////////////////////////////////////////////////
	logic [4:0] code_q, code_d;
	logic cont_q, cont_d, ien_q, ien_d, done_q, done_d;
	logic hwt_q, hwt_d, cmpe_q, cmpe_d, cmpg_q, cmpg_d;
	logic lp_q, lp_d, lsmp_q, lsmp_d;
	logic [1:0] csel_q, csel_d, div_q, div_d, mode_q, mode_d;
	logic [11:0] cv_q, cv_d, res_q, res_d;
	logic [15:0] pen_q, pen_d;
	logic wp_q, wp_d;
	logic [7:0] wa_q, wa_d;
	logic [31:0] rd_q, rd_d;
	logic acc, wr1, rdres, fin, dset, hit;
	logic [11:0] rnew, fres;
	acc_state_t st_q, st_d;

	// format the raw result right-justified
	function automatic logic [11:0] fmt(input logic [11:0] r, input logic [1:0] m);
		unique case (m)
			FM_8:    fmt = {4'h0, r[11:4]};
			FM_10:   fmt = {2'h0, r[11:2]};
			default: fmt = r;
		endcase
	endfunction : fmt

	////////////////////////////////////////////////////////////////
	// bus decode and register file next values
	always_comb begin
		acc   = hsel & htrans[1] & hready;
		wr1   = wp_q & (wa_q == OFS_CTRL1);
		rdres = acc & ~hwrite & (haddr[7:0] == OFS_RESULT);
		wp_d  = acc & hwrite;
		wa_d  = acc ? haddr[7:0] : wa_q;
		rd_d  = rd_q;
		if (acc & ~hwrite) begin
			rd_d = 32'h0;
			unique case (haddr[7:0])
				OFS_CTRL1:  rd_d[7:0] = {done_q, ien_q, cont_q, code_q};
				OFS_CTRL2:  rd_d[7:0] = {st_q != ST_IDLE, hwt_q, cmpe_q, cmpg_q, 4'h0};
				OFS_RESULT: rd_d[11:0] = res_q;
				OFS_CMPV:   rd_d[11:0] = cv_q;
				OFS_CFG:    rd_d[7:0] = {lp_q, div_q, lsmp_q, mode_q, csel_q};
				OFS_PIN1:   rd_d[7:0] = pen_q[7:0];
				OFS_PIN2:   rd_d[7:0] = pen_q[15:8];
				default:    rd_d = 32'h0;
			endcase
		end
		{ien_d, cont_d, code_d} = {ien_q, cont_q, code_q};
		{hwt_d, cmpe_d, cmpg_d} = {hwt_q, cmpe_q, cmpg_q};
		{lp_d, div_d, lsmp_d, mode_d, csel_d} = {lp_q, div_q, lsmp_q, mode_q, csel_q};
		cv_d  = cv_q;
		pen_d = pen_q;
		res_d = fin & hit ? fres : res_q;
		if (wp_q) begin
			unique case (wa_q)
				OFS_CTRL1: {ien_d, cont_d, code_d} = hwdata[6:0];
				OFS_CTRL2: {hwt_d, cmpe_d, cmpg_d} = hwdata[6:4];
				OFS_CMPV:  cv_d = hwdata[11:0];
				OFS_CFG:   {lp_d, div_d, lsmp_d, mode_d, csel_d} = hwdata[7:0];
				OFS_PIN1:  pen_d[7:0] = hwdata[7:0];
				OFS_PIN2:  pen_d[15:8] = hwdata[7:0];
				default:   ;
			endcase
		end
		// set wins over the read clear; a control write aborts instead
		dset   = fin & hit & ~wr1;
		done_d = dset | (done_q & ~wr1 & ~rdres);
	end

	// register file
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			code_q <= CODE_RST;
			{cont_q, ien_q, done_q, hwt_q, cmpe_q, cmpg_q} <= 6'h00;
			{lp_q, lsmp_q} <= 2'h0;
			{csel_q, div_q, mode_q} <= 6'h00;
			{cv_q, res_q} <= 24'h000000;
			pen_q <= 16'h0000;
			wp_q  <= 1'b0;
			wa_q  <= 8'h00;
			rd_q  <= 32'h0;
		end else begin
			{code_q, cont_q, ien_q, done_q} <= {code_d, cont_d, ien_d, done_d};
			{hwt_q, cmpe_q, cmpg_q} <= {hwt_d, cmpe_d, cmpg_d};
			{lp_q, lsmp_q, csel_q, div_q, mode_q} <= {lp_d, lsmp_d, csel_d, div_d, mode_d};
			{cv_q, res_q, pen_q} <= {cv_d, res_d, pen_d};
			{wp_q, wa_q, rd_q} <= {wp_d, wa_d, rd_d};
		end
	end

	////////////////////////////////////////////////////////////////
	logic [4:0] cnt_q, cnt_d;
	logic [3:0] bi_q, bi_d;
	logic [11:0] dac_q, dac_d;
	logic ph_q, ph_d, half_q, half_d, mt_q, mt_d;
	logic src, ctick, step, trig, shw, ssw;
	logic [11:0] pr_d;
	logic vl_d, vh_d, tp_d, bg_d, off_d, irq_d;

	// pick the conversion clock source; bus clock halts in stop3
	always_comb begin
		half_d = ~half_q;
		src = 1'b0;
		unique case (csel_q)
			CS_BUS:  src = ~stop3_mode;
			CS_HALF: src = ~stop3_mode & half_q;
			CS_ASYN: src = local_async_conv_clock;
			CS_ALT:  src = alternate_conv_clock & ~stop3_mode;
		endcase
	end

	// conversion clock divider
	acc_clk_div u_div (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.clr      (wr1),
		.src_tick (src),
		.div_sel  (div_q),
		.tick_q   (ctick)
	);

	// trigger, conversion sequence and analog selects
	always_comb begin
		mt_d = (rtc_count_value == rtc_modulo_value);
		trig = mt_d & ~mt_q;
		step = ctick & (~lp_q | ph_q);
		ph_d = ctick ? ~ph_q : ph_q;
		rnew = cmp_hi ? dac_q : dac_q & ~(12'h001 << bi_q);
		fres = fmt(rnew, mode_q);
		hit  = ~cmpe_q | (cmpg_q ? (fres >= cv_q) : (fres < cv_q));
		fin  = (st_q == ST_CONV) & step & (bi_q == 4'h0);
		ssw  = wr1 & (hwdata[4:0] != CODE_OFF) & ~hwt_d;
		shw  = trig & hwt_q & (code_q != CODE_OFF) & ~wr1;
		st_d = st_q;
		cnt_d = cnt_q;
		bi_d = bi_q;
		dac_d = dac_q;
		unique case (st_q)
			ST_IDLE: if (shw) st_d = ST_SMP;
			ST_SMP: begin
				if (step) begin
					if (cnt_q == 5'h00) begin
						st_d  = ST_CONV;
						bi_d  = MSB_IDX;
						dac_d = 12'h800;
					end else begin
						cnt_d = cnt_q - 5'h01;
					end
				end
			end
			ST_CONV: begin
				if (step) begin
					dac_d = rnew;
					if (bi_q == 4'h0) begin
						st_d = ST_FIN;
					end else begin
						bi_d  = bi_q - 4'h1;
						dac_d = rnew | (12'h001 << (bi_q - 4'h1));
					end
				end
			end
			ST_FIN: st_d = (cont_q & ~hwt_q) | shw ? ST_SMP : ST_IDLE;
		endcase
		if (wr1) begin
			st_d = ssw ? ST_SMP : ST_IDLE;
		end
		if ((st_q != ST_SMP) & (st_d == ST_SMP)) begin
			cnt_d = lsmp_q ? SMP_LONG : SMP_SHORT;
		end
		// reserved codes leave every select open
		pr_d = 12'h000;
		if (code_q <= CODE_PIN_LAST) begin
			pr_d = (12'h001 << code_q[3:0]) & pen_q[11:0];
		end
		vl_d  = (code_q > CODE_PIN_LAST & code_q <= CODE_VREFL_LAST)
			| (code_q == CODE_VREFL);
		vh_d  = (code_q == CODE_VREFH);
		tp_d  = (code_q == CODE_TEMP);
		bg_d  = (code_q == CODE_BGAP);
		off_d = (code_q == CODE_OFF);
		irq_d = done_d & ien_d;
	end

	// conversion state and outputs
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st_q  <= ST_IDLE;
			cnt_q <= 5'h00;
			bi_q  <= 4'h0;
			dac_q <= 12'h000;
			{ph_q, half_q, mt_q} <= 3'h0;
			pin_route <= 12'h000;
			{sel_vrefl, sel_vrefh, sel_temp, sel_bandgap} <= 4'h0;
			conv_off  <= 1'b1;
			sample_en <= 1'b0;
			dac_code  <= 12'h000;
			low_power <= 1'b0;
			conv_irq  <= 1'b0;
			hrdata    <= 32'h0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			bi_q  <= bi_d;
			dac_q <= dac_d;
			{ph_q, half_q, mt_q} <= {ph_d, half_d, mt_d};
			pin_route <= pr_d;
			{sel_vrefl, sel_vrefh, sel_temp, sel_bandgap} <= {vl_d, vh_d, tp_d, bg_d};
			conv_off  <= off_d;
			sample_en <= (st_d == ST_SMP);
			dac_code  <= dac_d;
			low_power <= lp_d;
			conv_irq  <= irq_d;
			hrdata    <= rd_d;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	property p_pin_gate;
		(code_q > CODE_PIN_LAST) |=> (pin_route == 12'h000);
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("pin routed");
	property p_temp;
		(code_q == CODE_TEMP) |=> sel_temp && !sel_vrefl && !sel_vrefh;
	endproperty
	a_temp: assert property (p_temp) else $error("temp select");
	property p_off;
		(code_q == CODE_OFF) && !wr1 ##1 (code_q == CODE_OFF) |-> conv_off && st_q == ST_IDLE;
	endproperty
	a_off: assert property (p_off) else $error("not off");
	property p_alt_wait;
		(csel_q == CS_ALT) && wait_mode && !stop3_mode && alternate_conv_clock |-> src;
	endproperty
	a_alt_wait: assert property (p_alt_wait) else $error("alt halted");
	property p_hw_start;
		shw && st_q == ST_IDLE |=> st_q == ST_SMP && sample_en;
	endproperty
	a_hw_start: assert property (p_hw_start) else $error("no hw start");
	property p_sw_start;
		ssw |=> st_q == ST_SMP && sample_en;
	endproperty
	a_sw_start: assert property (p_sw_start) else $error("no restart");
	property p_done_clr;
		wr1 |=> !done_q;
	endproperty
	a_done_clr: assert property (p_done_clr) else $error("done kept");
	property p_single;
		st_q == ST_FIN && !cont_q && !shw && !wr1 |=> st_q == ST_IDLE;
	endproperty
	a_single: assert property (p_single) else $error("no idle");
	property p_irq;
		dset && ien_q && !wp_q |=> done_q && conv_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("no irq");
	property p_one_trig;
		trig |=> !trig;
	endproperty
	a_one_trig: assert property (p_one_trig) else $error("double trig");

	c_single: cover property (st_q == ST_FIN && !cont_q ##1 st_q == ST_IDLE);
	c_cont: cover property (st_q == ST_FIN && cont_q ##1 st_q == ST_SMP);
	c_hw: cover property (shw && st_q == ST_IDLE);
	c_cmp: cover property (fin && cmpe_q && hit);
endmodule : acc_ctrl

/* File: verif/test_adc_channel_clock_trigger_control.sv */
`timescale 1ns/10ps
module test_adc_channel_clock_trigger_control;
	import acc_pkg::*;
	logic             ref_clk, srst, hsel, hwrite, hready, wait_mode, stop3_mode;
	logic             asyn_tick, alt_tick, cmp_hi, hreadyout, hresp, conv_irq;
	logic             sel_vrefl, sel_vrefh, sel_temp, sel_bandgap, conv_off;
	logic             sample_en, low_power;
	logic [31:0]      haddr, hwdata, hrdata, rd;
	logic [1:0]       htrans;
	logic [2:0]       hsize;
	logic [RTC_W-1:0] rtc_cnt, rtc_mod;
	logic [11:0]      pin_route, dac_code;
	logic [3:0]       tick_cnt = 4'h0;
	int               err_count, check_count;
	// rows: input select code, then pins, low ref, high ref, temp, bandgap, off
	logic [21:0] route_tab [12] = '{
		{5'h00, 12'h001, 5'h00}, {5'h0b, 12'h800, 5'h00}, {5'h0c, 12'h000, 5'h10},
		{5'h14, 12'h000, 5'h10}, {5'h15, 12'h000, 5'h00}, {5'h19, 12'h000, 5'h00},
		{5'h1a, 12'h000, 5'h04}, {5'h1b, 12'h000, 5'h02}, {5'h1c, 12'h000, 5'h00},
		{5'h1d, 12'h000, 5'h08}, {5'h1e, 12'h000, 5'h10}, {5'h1f, 12'h000, 5'h01}};
	// rows: config byte, then result with the comparator always high
	logic [19:0] conv_tab [5] = '{
		{8'h04, 12'hfff}, {8'h09, 12'h3ff}, {8'h02, 12'h0ff},
		{8'h0f, 12'hfff}, {8'hf4, 12'hfff}};

	assign hready = hreadyout;

	acc_ctrl acc_ctrl_inst (
		.ref_clk(ref_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wait_mode(wait_mode),
		.stop3_mode(stop3_mode), .local_async_conv_clock(asyn_tick),
		.alternate_conv_clock(alt_tick), .rtc_count_value(rtc_cnt),
		.rtc_modulo_value(rtc_mod), .cmp_hi(cmp_hi), .pin_route(pin_route),
		.sel_vrefl(sel_vrefl), .sel_vrefh(sel_vrefh), .sel_temp(sel_temp),
		.sel_bandgap(sel_bandgap), .conv_off(conv_off), .sample_en(sample_en),
		.dac_code(dac_code), .low_power(low_power), .conv_irq(conv_irq));

	////////////////////////////////////////////////////////////////////////////
	// clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	// local clock ticks every other cycle, reference clock every fourth
	always @(posedge ref_clk) begin
		tick_cnt <= tick_cnt + 4'h1;
		asyn_tick <= tick_cnt[0];
		alt_tick <= (tick_cnt[1:0] == 2'h0);
	end

	////////////////////////////////////////////////////////////////////////////
	// report and bus tasks
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		check_count++;
		if (got !== ex) begin
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
			err_count++;
		end
	endtask : chk

	// one single transfer; request held until ready, data taken at the second edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		hsize <= 3'h2;
		for (int ph = 0; ph < 2; ph++) begin
			n = 0;
			do begin
				@(posedge ref_clk);
				n++;
			end while (hready !== 1'b1 && n < 20);
			if (n >= 20) begin
				err_count++;
				give_verdict();
			end
			if (ph == 0) begin
				htrans <= 2'h0;
				hwdata <= d;
			end
		end
		rd = hrdata;
	endtask : bus

	task automatic idle(input int k);
		repeat (k) @(posedge ref_clk);
	endtask : idle

	// polls the done flag under a bound
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			bus(1'b0, OFS_CTRL1, 32'h0);
			n++;
		end while (rd[C1_DONE] !== 1'b1 && n < 400);
		chk("done", 32'h1, {31'h0, rd[C1_DONE]});
		if (n >= 400) begin
			give_verdict();
		end
	endtask : wait_done

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		err_count = 0;
		check_count = 0;
		srst = 1'b1;
		{hsel, hwrite, wait_mode, stop3_mode} = 4'h0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		hsize = 3'h2;
		cmp_hi = 1'b1;
		rtc_cnt = 8'h00;
		rtc_mod = 8'h05;
		idle(8);
		srst <= 1'b0;
		idle(1);
		chk("off_rst", 32'h1, {31'h0, conv_off});
		chk("rsp", 32'h2, {30'h0, hreadyout, hresp});
		bus(1'b0, OFS_CTRL1, 32'h0);
		chk("ctrl1_rst", 32'h1f, rd);
		bus(1'b0, 8'h1c, 32'h0);
		chk("unmapped", 32'h0, rd);
		bus(1'b1, OFS_PIN1, 32'hff);
		bus(1'b1, OFS_PIN2, 32'h0f);
		bus(1'b0, OFS_PIN2, 32'h0);
		chk("pin2", 32'h0f, rd);
		// input select decode, one row at a time
		foreach (route_tab[i]) begin
			bus(1'b1, OFS_CTRL1, {27'h0, route_tab[i][21:17]});
			idle(2);
			chk("route", {15'h0, route_tab[i][16:0]}, {15'h0, pin_route, sel_vrefl,
				sel_vrefh, sel_temp, sel_bandgap, conv_off});
		end
		// clock sources, formats, divider and low power
		foreach (conv_tab[i]) begin
			wait_mode <= (conv_tab[i][13:12] == CS_ALT);
			bus(1'b1, OFS_CFG, {24'h0, conv_tab[i][19:12]});
			bus(1'b1, OFS_CTRL1, 32'h40);
			wait_done();
			chk("irq", 32'h1, {31'h0, conv_irq});
			chk("dac", 32'hfff, {20'h0, dac_code});
			bus(1'b0, OFS_RESULT, 32'h0);
			chk("result", {20'h0, conv_tab[i][11:0]}, rd);
			bus(1'b0, OFS_CTRL1, 32'h0);
			chk("done_clr", 32'h40, rd);
			chk("idle", {31'h0, conv_tab[i][19]}, {31'h0, sample_en | low_power});
		end
		wait_mode <= 1'b0;
		// a disabled pin is not routed
		bus(1'b1, OFS_PIN1, 32'hfe);
		bus(1'b1, OFS_CFG, 32'h04);
		bus(1'b1, OFS_CTRL1, 32'h0);
		idle(2);
		chk("gated", 32'h0, {20'h0, pin_route});
		// compare greater-or-equal passes, less-than fails then passes
		bus(1'b1, OFS_CMPV, 32'h800);
		bus(1'b1, OFS_CTRL2, 32'h30);
		bus(1'b1, OFS_CTRL1, 32'h0);
		wait_done();
		bus(1'b1, OFS_CTRL2, 32'h20);
		bus(1'b1, OFS_CTRL1, 32'h0);
		idle(60);
		bus(1'b0, OFS_CTRL1, 32'h0);
		chk("lt_miss", 32'h0, rd);
		cmp_hi <= 1'b0;
		bus(1'b1, OFS_CTRL1, 32'h0);
		wait_done();
		bus(1'b0, OFS_RESULT, 32'h0);
		chk("lt_res", 32'h0, rd);
		// continuous mode restarts, all-ones code stops it
		cmp_hi <= 1'b1;
		bus(1'b1, OFS_CTRL2, 32'h0);
		bus(1'b1, OFS_CTRL1, 32'h20);
		wait_done();
		bus(1'b0, OFS_RESULT, 32'h0);
		wait_done();
		bus(1'b1, OFS_CTRL1, 32'h3f);
		idle(60);
		bus(1'b0, OFS_CTRL1, 32'h0);
		chk("stopped", 32'h3f, rd);
		// counter match trigger, one start per match, also in stop3
		bus(1'b1, OFS_CTRL2, 32'h40);
		bus(1'b1, OFS_CTRL1, 32'h0);
		idle(60);
		bus(1'b0, OFS_CTRL1, 32'h0);
		chk("no_sw", 32'h0, rd);
		rtc_cnt <= 8'h05;
		wait_done();
		bus(1'b0, OFS_RESULT, 32'h0);
		idle(60);
		bus(1'b0, OFS_CTRL1, 32'h0);
		chk("one_start", 32'h0, rd);
		rtc_cnt <= 8'h00;
		bus(1'b1, OFS_CFG, 32'h06);
		stop3_mode <= 1'b1;
		idle(2);
		rtc_cnt <= 8'h05;
		wait_done();
		stop3_mode <= 1'b0;
		give_verdict();
	end
endmodule : test_adc_channel_clock_trigger_control
